/* core/bit_store.sv */
// single-port one-bit cell array with registered read
`timescale 1ns/10ps
module bit_store #(
    parameter int ADDR_W = 19
) (
    input  wire logic              clk,
    input  wire logic              wrEn,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              wrData,
    output logic                   rdData
);
    // ---------------------------------------------------------------
    // storage
    // ---------------------------------------------------------------
    logic cells [0:(1<<ADDR_W)-1];

    // no reset on the array: contents are undefined until written
    always_ff @(posedge clk) begin
        if (wrEn) begin
            cells[addr] <= wrData;
        end
        rdData <= cells[addr];
    end
endmodule

/* core/serial_bit_memory_access.sv */
// serial one-bit memory access engine with address counters and bus status
//
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
module serial_bit_memory_access
    import serial_bit_memory_pkg::*;
#(
    parameter int REFRESH_WINDOW = REFRESH_WINDOW_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        serial_addr_in,
    input  wire logic        serial_addr_strobe,
    input  wire logic        addr_transfer_strobe,
    input  wire logic        access_clock_n,
    input  wire logic        count_direction,
    input  wire logic        refresh_mode_select,
    input  wire logic        refresh_pulse_in,
    input  wire logic        fast_access_select_n,
    input  wire logic        write_select_n,
    input  wire logic        write_data_in,
    input  wire logic        chip_select_n,
    output logic             read_data_out,
    output logic             read_data_oe,
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic [31:0]      readdata,
    output logic             waitrequest
);
    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    logic [PIN_N-1:0]   pinMeta_q;
    logic [PIN_N-1:0]   pinSync_q;
    logic [PIN_N-1:0]   pinPrev_q;
    logic               enable_q;
    logic [SHIFT_W-1:0] shiftReg_q;
    logic [ROW_W-1:0]   rowCnt_q;
    logic [COL_W-1:0]   colCnt_q;
    logic               rowPend_q;
    logic               fastMode_q;
    logic               dirUp_q;
    logic               accActive_q;
    logic               accWrite_q;
    logic               accRmw_q;
    logic [ADDR_W-1:0]  accAddr_q;
    logic               readPend_q;
    logic               refMissed_q;
    logic [REF_CNT_W-1:0] refCnt_q;
    logic [31:0]        winCnt_q;
    logic               sasRise;
    logic               tasFall;
    logic               accFall;
    logic               rmwFall;
    logic               refFall;
    logic               colWrap;
    logic               outOff;
    logic               memWe;
    logic [ADDR_W-1:0]  memAddr;
    logic               memRd;
    logic               busAck;
    logic               missClear;

    // column step in the given direction, wrapping inside the block
    function automatic logic [COL_W-1:0] stepCol(input logic [COL_W-1:0] c, input logic up);
        stepCol = up ? c + 10'h001 : c - 10'h001;
    endfunction

    // ---------------------------------------------------------------
    // pin synchronisers: all pins are asynchronous to clk
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pinMeta_q <= 11'h7FF;
            pinSync_q <= 11'h7FF;
            pinPrev_q <= 11'h7FF;
        end else begin
            pinMeta_q <= {chip_select_n, write_data_in, write_select_n, fast_access_select_n,
                          refresh_pulse_in, refresh_mode_select, count_direction,
                          access_clock_n, addr_transfer_strobe, serial_addr_strobe,
                          serial_addr_in};
            pinSync_q <= pinMeta_q;
            pinPrev_q <= pinSync_q;
        end
    end

    // edge detects look only at the second and third stages
    always_comb begin
        sasRise = enable_q & pinSync_q[PIN_SAS] & ~pinPrev_q[PIN_SAS];
        tasFall = enable_q & ~pinSync_q[PIN_TAS] & pinPrev_q[PIN_TAS];
        accFall = enable_q & ~pinSync_q[PIN_ACCESS_CLOCK_N] & pinPrev_q[PIN_ACCESS_CLOCK_N]
                & ~pinSync_q[PIN_CS];
        rmwFall = accActive_q & ~accWrite_q & ~accRmw_q
                & ~pinSync_q[PIN_WE] & pinPrev_q[PIN_WE];
        refFall = enable_q & pinSync_q[PIN_RSEL] & pinSync_q[PIN_ACCESS_CLOCK_N]
                & ~pinSync_q[PIN_RFP] & pinPrev_q[PIN_RFP];
        colWrap = dirUp_q ? (colCnt_q == COL_FIRST_DN) : (colCnt_q == COL_FIRST_UP);
        outOff  = ~enable_q | pinSync_q[PIN_ACCESS_CLOCK_N] | pinSync_q[PIN_CS];
    end

    // ---------------------------------------------------------------
    // serial address shifter
    // ---------------------------------------------------------------
    // A0 arrives first and ends in bit 0 after ten strobes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            shiftReg_q <= '0;
        end else if (sasRise) begin
            shiftReg_q <= {pinSync_q[PIN_SAD], shiftReg_q[SHIFT_W-1:1]};
        end
    end

    // ---------------------------------------------------------------
    // fast mode and direction
    // ---------------------------------------------------------------
    // fast select is only looked at while the access clock is low
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fastMode_q <= 1'b0;
        end else if (!pinSync_q[PIN_ACCESS_CLOCK_N]) begin
            fastMode_q <= ~pinSync_q[PIN_FAST];
        end
    end

    // direction is frozen through fast mode
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dirUp_q <= 1'b1;
        end else if (!fastMode_q) begin
            dirUp_q <= pinSync_q[PIN_DIR];
        end
    end

    // ---------------------------------------------------------------
    // row and column counters
    // ---------------------------------------------------------------
    // transfer wins over an access that lands in the same cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rowCnt_q  <= '0;
            colCnt_q  <= '0;
            rowPend_q <= 1'b0;
        end else if (tasFall) begin
            rowCnt_q  <= shiftReg_q[ROW_W-1:0];
            colCnt_q  <= dirUp_q ? COL_FIRST_UP : COL_FIRST_DN;
            rowPend_q <= 1'b0;
        end else if (accFall) begin
            colCnt_q <= stepCol(colCnt_q, dirUp_q);
            // a wrap seen in fast mode waits for the next normal cycle
            if (!fastMode_q && (colWrap || rowPend_q)) begin
                rowCnt_q <= dirUp_q ? rowCnt_q + 9'h001 : rowCnt_q - 9'h001;
            end
            rowPend_q <= fastMode_q & (colWrap | rowPend_q);
        end
    end

    // ---------------------------------------------------------------
    // access tracking
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            accActive_q <= 1'b0;
            accWrite_q  <= 1'b0;
            accRmw_q    <= 1'b0;
            accAddr_q   <= '0;
            readPend_q  <= 1'b0;
        end else begin
            readPend_q <= accFall & pinSync_q[PIN_WE];
            if (accFall) begin
                accActive_q <= 1'b1;
                accWrite_q  <= ~pinSync_q[PIN_WE];
                accRmw_q    <= 1'b0;
                accAddr_q   <= {rowCnt_q, colCnt_q};
            end else if (outOff) begin
                accActive_q <= 1'b0;
            end else if (rmwFall) begin
                accRmw_q <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // cell array port
    // ---------------------------------------------------------------
    // rmw write goes back to the cell the access was opened on
    always_comb begin
        memWe   = (accFall & ~pinSync_q[PIN_WE]) | rmwFall;
        memAddr = rmwFall ? accAddr_q : {rowCnt_q, colCnt_q};
    end

    bit_store #(
        .ADDR_W (ADDR_W)
    ) u_store (
        .clk    (clk),
        .wrEn   (memWe),
        .addr   (memAddr),
        .wrData (pinSync_q[PIN_DIN]),
        .rdData (memRd)
    );

    // ---------------------------------------------------------------
    // data output
    // ---------------------------------------------------------------
    // the read bit is held until the access clock or chip select returns high, or enable is cleared
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            read_data_out <= 1'b0;
            read_data_oe  <= 1'b0;
        end else if (outOff) begin
            read_data_oe <= 1'b0;
        end else if (readPend_q) begin
            read_data_out <= memRd;
            read_data_oe  <= 1'b1;
        end else if (accFall) begin
            read_data_oe <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // refresh supervision
    // ---------------------------------------------------------------
    // self refresh needs no pulses, so the window only runs in auto mode
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            winCnt_q <= '0;
            refCnt_q <= '0;
        end else if (!pinSync_q[PIN_RSEL] || winCnt_q == 32'(REFRESH_WINDOW - 1)) begin
            winCnt_q <= '0;
            refCnt_q <= '0;
        end else begin
            winCnt_q <= winCnt_q + 32'h0000_0001;
            if (refFall && refCnt_q != {REF_CNT_W{1'b1}}) begin
                refCnt_q <= refCnt_q + 11'h001;
            end
        end
    end

    assign missClear = write & ~waitrequest & (address == OFS_REFRESH)
                     & writedata[REF_MISS_BIT];

    // a miss in the clearing cycle still sets the flag
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            refMissed_q <= 1'b0;
        end else if (pinSync_q[PIN_RSEL] && winCnt_q == 32'(REFRESH_WINDOW - 1)
                     && refCnt_q < 11'(REFRESH_PULSES)) begin
            refMissed_q <= 1'b1;
        end else if (missClear) begin
            refMissed_q <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Avalon-MM slave
    // ---------------------------------------------------------------
    // one wait cycle per transfer keeps readdata and waitrequest registered
    assign busAck = (read | write) & waitrequest;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= ~busAck;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            enable_q <= CTRL_EN_RESET;
        end else if (write && !waitrequest && address == OFS_CTRL) begin
            enable_q <= writedata[CTRL_EN_BIT];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            readdata <= '0;
        end else if (busAck && read) begin
            readdata <= '0;
            if (address == OFS_CTRL) begin
                readdata[CTRL_EN_BIT] <= enable_q;
            end else if (address == OFS_STATUS) begin
                readdata[COL_W-1:0]                     <= colCnt_q;
                readdata[STAT_ROW_LSB +: ROW_W]         <= rowCnt_q;
                readdata[STAT_FAST_BIT]                 <= fastMode_q;
                readdata[STAT_DIR_BIT]                  <= dirUp_q;
                readdata[STAT_RMW_BIT]                  <= accRmw_q;
            end else if (address == OFS_REFRESH) begin
                readdata[REF_CNT_W-1:0] <= refCnt_q;
                readdata[REF_MISS_BIT]  <= refMissed_q;
            end else if (address == OFS_SHIFT) begin
                readdata[SHIFT_W-1:0] <= shiftReg_q;
            end
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    sequence readOpen;
        accFall && pinSync_q[PIN_WE];
    endsequence

    sequence driveBit;
        ##1 readPend_q ##1 (read_data_oe == !$past(outOff));
    endsequence

    a_shift_capture: assert property (@(posedge clk) disable iff (!reset_n)
        sasRise |=> shiftReg_q[SHIFT_W-1] == $past(pinSync_q[PIN_SAD]))
        else $error("serial address bit not captured");

    a_transfer_row: assert property (@(posedge clk) disable iff (!reset_n)
        tasFall |=> rowCnt_q == $past(shiftReg_q[ROW_W-1:0]))
        else $error("row counter not loaded by transfer");

    a_transfer_col: assert property (@(posedge clk) disable iff (!reset_n)
        tasFall |=> colCnt_q == ($past(dirUp_q) ? COL_FIRST_UP : COL_FIRST_DN))
        else $error("column counter start value wrong");

    a_column_step: assert property (@(posedge clk) disable iff (!reset_n)
        accFall && !tasFall |=> colCnt_q == stepCol($past(colCnt_q), $past(dirUp_q)))
        else $error("column counter did not step");

    a_read_drive: assert property (@(posedge clk) disable iff (!reset_n)
        readOpen |-> driveBit)
        else $error("read bit not driven two cycles after clock fall");

    a_output_off: assert property (@(posedge clk) disable iff (!reset_n)
        outOff || (accFall && !pinSync_q[PIN_WE]) |=> !read_data_oe)
        else $error("data output driven while it must be off");

    a_write_store: assert property (@(posedge clk) disable iff (!reset_n)
        accFall && !pinSync_q[PIN_WE] |-> memWe && memAddr == {rowCnt_q, colCnt_q})
        else $error("write access did not store at current address");

    a_rmw_store: assert property (@(posedge clk) disable iff (!reset_n)
        rmwFall |-> memWe && memAddr == accAddr_q)
        else $error("rmw write not at the opened cell");

    a_fast_dir: assert property (@(posedge clk) disable iff (!reset_n)
        fastMode_q && $past(fastMode_q) |-> $stable(dirUp_q))
        else $error("direction changed in fast mode");

    a_row_step: assert property (@(posedge clk) disable iff (!reset_n)
        accFall && !tasFall && colWrap && !fastMode_q && dirUp_q
        |=> rowCnt_q == $past(rowCnt_q) + 9'h001)
        else $error("row did not step after block end");

    a_bus_answer: assert property (@(posedge clk) disable iff (!reset_n)
        (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("bus answer not one cycle after request");
endmodule

/* pkg/serial_bit_memory_pkg.sv */
// constants shared by the serial bit memory access block
package serial_bit_memory_pkg;
    // ---------------------------------------------------------------
    // geometry
    // ---------------------------------------------------------------
    localparam int          COL_W        = 10;
    localparam int          ROW_W        = 9;
    localparam int          SHIFT_W      = 10;
    localparam int          ADDR_W       = ROW_W + COL_W;
    localparam logic [9:0]  COL_FIRST_UP = 10'h000;
    localparam logic [9:0]  COL_FIRST_DN = 10'h3FF;

    // ---------------------------------------------------------------
    // pin positions inside the synchroniser vector
    // ---------------------------------------------------------------
    localparam int PIN_N    = 11;
    localparam int PIN_SAD  = 0;
    localparam int PIN_SAS  = 1;
    localparam int PIN_TAS  = 2;
    localparam int PIN_ACCESS_CLOCK_N = 3;
    localparam int PIN_DIR  = 4;
    localparam int PIN_RSEL = 5;
    localparam int PIN_RFP  = 6;
    localparam int PIN_FAST = 7;
    localparam int PIN_WE   = 8;
    localparam int PIN_DIN  = 9;
    localparam int PIN_CS   = 10;

    // ---------------------------------------------------------------
    // register map (byte offsets) and fields
    // ---------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL    = 4'h0;
    localparam logic [3:0] OFS_STATUS  = 4'h4;
    localparam logic [3:0] OFS_REFRESH = 4'h8;
    localparam logic [3:0] OFS_SHIFT   = 4'hC;
    localparam int         CTRL_EN_BIT     = 0;
    localparam logic       CTRL_EN_RESET   = 1'b1;
    localparam int         STAT_ROW_LSB    = 10;
    localparam int         STAT_FAST_BIT   = 19;
    localparam int         STAT_DIR_BIT    = 20;
    localparam int         STAT_RMW_BIT    = 21;
    localparam int         REF_CNT_W       = 11;
    localparam int         REF_MISS_BIT    = 16;

    // ---------------------------------------------------------------
    // refresh timing
    // ---------------------------------------------------------------
    localparam int REFRESH_PULSES    = 1024;
    localparam int REFRESH_WINDOW_MS = 100;
    localparam int CLK_KHZ           = 250000;
    localparam int REFRESH_WINDOW_CYCLES = REFRESH_WINDOW_MS * CLK_KHZ;
endpackage

/* tb/access_ctrl_model.sv */
// controller-side model that sequences the serial memory pins
`timescale 1ns/10ps
module access_ctrl_model (
    input  wire logic clk,
    output logic      serial_addr_in,
    output logic      serial_addr_strobe,
    output logic      addr_transfer_strobe,
    output logic      access_clock_n,
    output logic      count_direction,
    output logic      refresh_mode_select,
    output logic      refresh_pulse_in,
    output logic      fast_access_select_n,
    output logic      write_select_n,
    output logic      write_data_in,
    output logic      chip_select_n
);
    // ------------------------------------------------------------
    // idle levels and pin sequences
    // ------------------------------------------------------------
    // idle: strobes and clock high; auto refresh keeps the watchdog live
    initial begin
        serial_addr_in = 1'b0;
        serial_addr_strobe = 1'b1;
        addr_transfer_strobe = 1'b1;
        access_clock_n = 1'b1;
        count_direction = 1'b1;
        refresh_mode_select = 1'b1;
        refresh_pulse_in = 1'b1;
        fast_access_select_n = 1'b1;
        write_select_n = 1'b1;
        write_data_in = 1'b0;
        chip_select_n = 1'b0;
    end
    // twice the spacing the input synchronisers need
    task automatic gap();
        repeat (8) @(posedge clk);
    endtask
    // block number goes out A0 first, top bit forced low
    task automatic shift(input logic [9:0] blk);
        for (int i = 0; i < 10; i++) begin
            serial_addr_in <= (i == 9) ? 1'b0 : blk[i];
            serial_addr_strobe <= 1'b0;
            gap();
            serial_addr_strobe <= 1'b1;
            gap();
        end
        serial_addr_in <= 1'b1;  // released line shows inverse of last bit
    endtask
    // direction moves here; the bench moves it once in fast mode to see it held
    task automatic transfer(input logic up);
        count_direction <= up;
        gap();
        addr_transfer_strobe <= 1'b0;
        gap();
        addr_transfer_strobe <= 1'b1;
        gap();
    endtask
    task automatic clk_fall(input logic weN, input logic din);
        write_select_n <= weN;
        write_data_in <= din;
        gap();
        access_clock_n <= 1'b0;
        gap();
    endtask
    // data flips once taken, so a late latch shows up
    task automatic clk_rise();
        write_data_in <= ~write_data_in;
        access_clock_n <= 1'b1;
        gap();
        write_select_n <= 1'b1;
        @(posedge clk);  // next task may drive write select again
    endtask
    // write select falls inside a read access, data flips after it
    task automatic rmw(input logic din);
        write_data_in <= din;
        gap();
        write_select_n <= 1'b0;
        gap();
        write_data_in <= ~din;
        gap();
    endtask
    task automatic select(input logic v);
        chip_select_n <= v;
        gap();
    endtask
    // fast select moves only while the access clock is low
    task automatic fast(input logic v);
        fast_access_select_n <= v;
        gap();
    endtask
    task automatic set_mode(input logic v);
        refresh_mode_select <= v;
        gap();
    endtask
    // refresh pulses only while the access clock rests high
    task automatic refresh(input int n);
        repeat (n) begin
            refresh_pulse_in <= 1'b0;
            gap();
            refresh_pulse_in <= 1'b1;
            gap();
        end
    endtask
    // eight dummy reads before stored data is trusted
    task automatic warmup();
        repeat (8) begin
            clk_fall(1'b1, 1'b0);
            clk_rise();
        end
    endtask
endmodule

/* tb/tb_serial_bit_memory_access.sv */
// self-checking bench for the serial bit memory access block
`timescale 1ns/10ps
module tb_serial_bit_memory_access;
    import serial_bit_memory_pkg::*;
    // ------------------------------------------------------------
    // signals, clock and instances
    // ------------------------------------------------------------
    typedef struct packed {logic [9:0] blk; logic up; logic [3:0] bits; logic [9:0] colEnd;} row_t;
    logic        clk, reset_n, read, write, waitrequest, read_data_out, read_data_oe;
    logic        serial_addr_in, serial_addr_strobe, addr_transfer_strobe, access_clock_n;
    logic        count_direction, refresh_mode_select, refresh_pulse_in, fast_access_select_n;
    logic        write_select_n, write_data_in, chip_select_n;
    logic [3:0]  address;
    logic [31:0] writedata, readdata, q;
    int          badCount = 0;
    int          cmpCount = 0;
    row_t        rows [3] = '{'{10'h005, 1'b1, 4'hA, 10'h004},
                             '{10'h1FF, 1'b0, 4'h6, 10'h3FB},
                             '{10'h000, 1'b1, 4'hF, 10'h004}};
    // free-running bench clock
    always #2 clk = ~clk;
    serial_bit_memory_access #(.REFRESH_WINDOW(2000)) DUT (
        .clk, .reset_n, .serial_addr_in, .serial_addr_strobe, .addr_transfer_strobe,
        .access_clock_n, .count_direction, .refresh_mode_select, .refresh_pulse_in,
        .fast_access_select_n, .write_select_n, .write_data_in, .chip_select_n,
        .read_data_out, .read_data_oe, .address, .read, .write, .writedata,
        .readdata, .waitrequest);
    access_ctrl_model ctl (
        .clk, .serial_addr_in, .serial_addr_strobe, .addr_transfer_strobe,
        .access_clock_n, .count_direction, .refresh_mode_select, .refresh_pulse_in,
        .fast_access_select_n, .write_select_n, .write_data_in, .chip_select_n);
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            badCount++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // one bus cycle held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n = 0;
        address <= a;
        writedata <= d;
        write <= w;
        read <= ~w;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
        chk("bus answer", 32'(n < 50), 32'h1);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmpCount, badCount);
        if (badCount == 0 && cmpCount > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // watchdog sized well above the 30k cycles the tests need
    initial begin
        repeat (80000) @(posedge clk);
        badCount++;
        final_report();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        {read, write, address, writedata} = '0;
        repeat (10) @(posedge clk);
        chk("wait in reset", waitrequest, 1'b1);
        chk("oe in reset", read_data_oe, 1'b0);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        ctl.warmup();
        bus(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl", q[CTRL_EN_BIT], CTRL_EN_RESET);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk("col warmup", q[9:0], 10'h008);
        chk("dir reset", q[STAT_DIR_BIT], 1'b1);
        bus(1'b1, 4'h6, 32'hFFFFFFFF);
        bus(1'b0, 4'h6, 32'h0);
        chk("unmapped", q, 32'h0);
        $display("reset test done");
        foreach (rows[r]) begin
            ctl.shift(rows[r].blk);
            ctl.transfer(rows[r].up);
            for (int b = 0; b < 4; b++) begin
                ctl.clk_fall(1'b0, rows[r].bits[b]);
                chk("oe write", read_data_oe, 1'b0);
                ctl.clk_rise();
            end
            ctl.transfer(rows[r].up);
            for (int b = 0; b < 4; b++) begin
                ctl.clk_fall(1'b1, 1'b0);
                chk("read bit", read_data_out, rows[r].bits[b]);
                chk("oe read", read_data_oe, 1'b1);
                ctl.clk_rise();
                chk("oe idle", read_data_oe, 1'b0);
            end
            bus(1'b0, OFS_SHIFT, 32'h0);
            chk("shift", q[9:0], rows[r].blk);
            bus(1'b0, OFS_STATUS, 32'h0);
            chk("col", q[9:0], rows[r].colEnd);
            chk("row", q[STAT_ROW_LSB +: ROW_W], rows[r].blk[8:0]);
            $display("row case %0d done", r);
        end
        // write select falling in a read access stores the data held at its fall
        ctl.shift(10'h003);
        ctl.transfer(1'b1);
        ctl.clk_fall(1'b1, 1'b0);
        ctl.rmw(1'b1);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk("rmw flag", q[STAT_RMW_BIT], 1'b1);
        ctl.clk_rise();
        ctl.transfer(1'b1);
        ctl.clk_fall(1'b1, 1'b0);
        chk("rmw data", read_data_out, 1'b1);
        ctl.clk_rise();
        $display("rmw test done");
        // deselected access neither drives nor steps
        ctl.select(1'b1);
        ctl.clk_fall(1'b1, 1'b0);
        chk("oe deselected", read_data_oe, 1'b0);
        ctl.clk_rise();
        ctl.select(1'b0);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk("col deselected", q[9:0], 10'h001);
        $display("select test done");
        // direction and start column stay frozen while fast mode is held
        ctl.clk_fall(1'b1, 1'b0);
        ctl.fast(1'b0);
        ctl.transfer(1'b0);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk("fast flag", q[STAT_FAST_BIT], 1'b1);
        chk("dir frozen", q[STAT_DIR_BIT], 1'b1);
        chk("col frozen", q[9:0], COL_FIRST_UP);
        ctl.fast(1'b1);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk("dir free", q[STAT_DIR_BIT], 1'b0);
        ctl.clk_rise();
        $display("fast test done");
        // a full block of writes carries into the row counter
        ctl.shift(10'h007);
        ctl.transfer(1'b1);
        repeat (1024) begin
            ctl.clk_fall(1'b0, 1'b1);
            ctl.clk_rise();
        end
        bus(1'b0, OFS_STATUS, 32'h0);
        chk("col wrap", q[9:0], 10'h000);
        chk("row wrap", q[STAT_ROW_LSB +: ROW_W], 9'h008);
        $display("wrap test done");
        // no pulses given, so every window ends short
        bus(1'b0, OFS_REFRESH, 32'h0);
        chk("refresh miss", q[REF_MISS_BIT], 1'b1);
        // self refresh stops the window, so no new miss can race the clear
        ctl.set_mode(1'b0);
        bus(1'b1, OFS_REFRESH, 32'h1 << REF_MISS_BIT);
        bus(1'b0, OFS_REFRESH, 32'h0);
        chk("miss cleared", q[REF_MISS_BIT], 1'b0);
        ctl.set_mode(1'b1);
        ctl.refresh(5);
        bus(1'b0, OFS_REFRESH, 32'h0);
        chk("pulse count", q[REF_CNT_W-1:0], 11'h005);
        $display("refresh test done");
        final_report();
    end
endmodule
